// ==== common/hsps_regs.svh ====
// timing figures, register offsets, field positions and reset values
`ifndef HSPS_REGS_SVH
`define HSPS_REGS_SVH
`define HSPS_CLK_MHZ       125
`define HSPS_US_CYC        (`HSPS_CLK_MHZ * 1)
`define HSPS_MS_US         1000
`define HSPS_UV_FILT_MS    1.0
`define HSPS_OV_FILT_MS    1.0
`define HSPS_DIS_FILT_MS   1.0
`define HSPS_SC_MAX_US     10
`define HSPS_OC_FILT_US    100
`define HSPS_OC_REG_MS     3.0
`define HSPS_PG_DLY_MS     28
`define HSPS_OT_FILT_US    12
`define HSPS_TMR_DEF_MS    200
`define HSPS_TMR_MIN_MS    100
`define HSPS_TMR_MAX_MS    1000
`define HSPS_RETRY_MAX     10
`define HSPS_UV_FILT_US    ($rtoi(`HSPS_UV_FILT_MS * 1000.0))
`define HSPS_OV_FILT_US    ($rtoi(`HSPS_OV_FILT_MS * 1000.0))
`define HSPS_DIS_FILT_US   ($rtoi(`HSPS_DIS_FILT_MS * 1000.0))
`define HSPS_OC_REG_US     ($rtoi(`HSPS_OC_REG_MS * 1000.0))
`define HSPS_PG_DLY_US     (`HSPS_PG_DLY_MS * 1000)
`define HSPS_SC_MAX_CYC    (`HSPS_SC_MAX_US * `HSPS_US_CYC)
`define HSPS_OFS_CTRL      4'h0
`define HSPS_OFS_STAT      4'h4
`define HSPS_OFS_TMR       4'h8
`define HSPS_CTRL_SOFTDIS  0
`define HSPS_CTRL_RST      32'h0000_0000
`define HSPS_STAT_STATE    0
`define HSPS_STAT_RETRY    4
`define HSPS_STAT_UV       8
`define HSPS_STAT_OV       9
`define HSPS_STAT_OT       10
`define HSPS_STAT_DIS      11
`define HSPS_STAT_OC       12
`define HSPS_STAT_PG       13
`endif

// ==== common/hsps_pkg.sv ====
// shared types of the hot swap sequencer
package hsps_pkg;
    typedef enum logic [2:0] {
        HSPS_WAIT   = 3'h0,
        HSPS_CHARGE = 3'h1,
        HSPS_PGDLY  = 3'h3,
        HSPS_NORMAL = 3'h2,
        HSPS_OCREG  = 3'h6
    } hsps_state_e;

    typedef struct packed {
        logic oc;
        logic ot;
        logic en;
        logic dis;
        logic ov;
        logic uv;
    } hsps_flt_s;

    typedef struct packed {
        logic       gate_full;
        logic       sc;
        logic       oc;
        logic       ot;
        logic       dis_lo;
        logic       dis_hi;
        logic       ov;
        logic       uv;
    } hsps_raw_s;

    typedef struct packed {
        hsps_state_e state;
        logic [7:0]  us_cnt;
        logic [9:0]  ms_cnt;
        logic [9:0]  tmr;
        logic [15:0] itv;
        logic [3:0]  retry;
        logic        dis;
        logic        ot_prev;
        logic        soft_dis;
        logic        gate;
        logic        chg;
        logic        regl;
        logic        pg;
        logic        pg_n;
        logic        wait_r;
        logic [31:0] rdata;
    } hsps_top_s;
endpackage

// ==== rtl/hsps_sync.sv ====
// two-stage synchroniser for a group of indications
`timescale 1ns/1ns
`default_nettype none
module hsps_sync
    import hsps_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clock_i,
    input  wire logic         reset_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } hsps_sync_s;

    hsps_sync_s s_q;
    hsps_sync_s s_d;

    always_comb begin
        s_d.s1 = async_i;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.s2;
endmodule
`default_nettype wire

// ==== rtl/hsps_filt.sv ====
// persistence filter: output rises after CNT ticks of steady input
`timescale 1ns/1ns
`default_nettype none
module hsps_filt
    import hsps_pkg::*;
#(
    parameter int CNT = 1000
) (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    input  wire logic tick_i,
    input  wire logic level_i,
    output logic      hit_o
);
    localparam int CW = $clog2(CNT + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          hit;
    } hsps_filt_s;

    hsps_filt_s s_q;
    hsps_filt_s s_d;

    if (CNT < 1) begin : g_chk
        $error("hsps_filt: CNT must be at least 1");
    end

    always_comb begin
        s_d = s_q;
        if (!level_i) begin
            s_d.cnt = '0;
        end else if (tick_i && s_q.cnt != CW'(CNT)) begin
            s_d.cnt = s_q.cnt + CW'(1);
        end
        s_d.hit = level_i && (s_d.cnt == CW'(CNT));
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign hit_o = s_q.hit;
endmodule
`default_nettype wire

// ==== rtl/hsps_top.sv ====
// hot swap protection sequencer with avalon-mm status and control
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`include "hsps_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module hsps_top
    import hsps_pkg::*;
#(
    parameter int US_CYC  = `HSPS_US_CYC,
    parameter int MS_US   = `HSPS_MS_US,
    parameter int UV_US   = `HSPS_UV_FILT_US,
    parameter int OV_US   = `HSPS_OV_FILT_US,
    parameter int DIS_US  = `HSPS_DIS_FILT_US,
    parameter int OCF_US  = `HSPS_OC_FILT_US,
    parameter int OT_US   = `HSPS_OT_FILT_US,
    parameter int OCR_US  = `HSPS_OC_REG_US,
    parameter int PGD_US  = `HSPS_PG_DLY_US
) (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    input  wire logic        undervolt_sense_i,
    input  wire logic        overvolt_sense_i,
    input  wire logic        disable_above_i,
    input  wire logic        disable_below_i,
    input  wire logic        overtemp_i,
    input  wire logic        overcurrent_i,
    input  wire logic        short_circuit_i,
    input  wire logic        gate_full_i,
    input  wire logic        timer_ext_present_i,
    input  wire logic [9:0]  timer_ext_ms_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [3:0]  avs_byteenable_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             gate_on_o,
    output logic             charge_limit_sel_o,
    output logic             regulate_o,
    output logic             power_ok_high_o,
    output logic             power_ok_low_n_o
);
    // ****************************************
    // elaboration checks
    // ****************************************
    if (US_CYC < 1 || US_CYC > 255 || MS_US < 1 || MS_US > 1023) begin : g_chk_tb
        $error("hsps_top: time base out of range");
    end
    if (OCR_US > 65535 || PGD_US > 65535) begin : g_chk_itv
        $error("hsps_top: interval exceeds counter");
    end
    if (4 > `HSPS_SC_MAX_CYC) begin : g_chk_sc
        $error("hsps_top: short circuit path too slow");
    end

    function automatic logic [9:0] sel_ms(input logic present, input logic [9:0] val);
        logic [9:0] r;
        r = 10'(`HSPS_TMR_DEF_MS);
        if (present) begin
            r = val;
            if (val < 10'(`HSPS_TMR_MIN_MS)) begin
                r = 10'(`HSPS_TMR_MIN_MS);
            end
            if (val > 10'(`HSPS_TMR_MAX_MS)) begin
                r = 10'(`HSPS_TMR_MAX_MS);
            end
        end
        return r;
    endfunction

    function automatic int flt_cnt(input int i);
        case (i)
            0:       return UV_US;
            1:       return OV_US;
            2:       return DIS_US;
            3:       return DIS_US;
            4:       return OT_US;
            default: return OCF_US;
        endcase
    endfunction

    // ****************************************
    // synchronisers and filters
    // ****************************************
    hsps_top_s  s_q;
    hsps_top_s  s_d;
    hsps_raw_s  raw_a;
    hsps_raw_s  raw_s;
    hsps_flt_s  lvl;
    hsps_flt_s  flt;
    logic       tick_us;
    logic       tick_ms;
    logic       dis_s;
    logic [9:0] tmr_ms;

    assign raw_a = '{gate_full: gate_full_i, sc: short_circuit_i, oc: overcurrent_i,
                     ot: overtemp_i, dis_lo: disable_below_i, dis_hi: disable_above_i,
                     ov: overvolt_sense_i, uv: undervolt_sense_i};

    hsps_sync #(.W($bits(hsps_raw_s))) u_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .async_i (raw_a),
        .sync_o  (raw_s)
    );

    assign dis_s = raw_s.dis_hi | raw_s.dis_lo | s_q.soft_dis;
    assign lvl   = '{oc: raw_s.oc, ot: raw_s.ot, en: ~dis_s, dis: dis_s,
                     ov: raw_s.ov, uv: raw_s.uv};

    assign tick_us = (s_q.us_cnt == 8'(US_CYC - 1));
    assign tick_ms = tick_us && (s_q.ms_cnt == 10'(MS_US - 1));
    assign tmr_ms  = sel_ms(timer_ext_present_i, timer_ext_ms_i);

    for (genvar i = 0; i < $bits(hsps_flt_s); i++) begin : g_flt
        hsps_filt #(.CNT(flt_cnt(i))) u_filt (
            .clock_i (clock_i),
            .reset_i (reset_i),
            .ce_i    (ce_i),
            .tick_i  (tick_us),
            .level_i (lvl[i]),
            .hit_o   (flt[i])
        );
    end

    // ****************************************
    // sequencer and register slave
    // ****************************************
    logic start_ok;
    logic acc;
    logic ot_on;
    logic sc_any;

    always_comb begin
        s_d = s_q;
        start_ok = !flt.uv && !flt.ov && !flt.ot && !s_q.dis && !flt.dis;
        acc      = flt.dis && !s_q.dis;
        ot_on    = flt.ot && !s_q.ot_prev;
        sc_any   = raw_s.sc;
        s_d.ot_prev = flt.ot;
        s_d.us_cnt  = tick_us ? 8'h00 : s_q.us_cnt + 8'h01;
        if (tick_us) begin
            s_d.ms_cnt = tick_ms ? 10'h000 : s_q.ms_cnt + 10'h001;
        end
        if (acc) begin
            s_d.dis = 1'b1;
        end else if (flt.en && s_q.dis) begin
            s_d.dis = 1'b0;
        end
        case (s_q.state)
            HSPS_WAIT: begin
                if (acc && s_q.retry > 4'(`HSPS_RETRY_MAX)) begin
                    s_d.retry = 4'h0;
                end else if ((acc || ot_on) && s_q.retry != 4'hF) begin
                    s_d.retry = s_q.retry + 4'h1;
                end
                if (!start_ok) begin
                    s_d.tmr = 10'h000;
                end else if (tick_ms && s_q.tmr != 10'h3FF) begin
                    s_d.tmr = s_q.tmr + 10'h001;
                end
                if (start_ok && s_q.tmr >= tmr_ms && s_q.retry <= 4'(`HSPS_RETRY_MAX)) begin
                    s_d.state = HSPS_CHARGE;
                    s_d.tmr   = 10'h000;
                end
            end
            HSPS_CHARGE: begin
                if (raw_s.gate_full) begin
                    s_d.state = HSPS_PGDLY;
                    s_d.itv   = 16'h0000;
                end
            end
            HSPS_PGDLY: begin
                if (tick_us) begin
                    s_d.itv = s_q.itv + 16'h0001;
                end
                if (s_q.itv >= 16'(PGD_US)) begin
                    s_d.state = HSPS_NORMAL;
                    s_d.retry = 4'h0;
                end
            end
            HSPS_NORMAL: begin
                if (flt.oc || sc_any) begin
                    s_d.state = HSPS_OCREG;
                    s_d.itv   = 16'h0000;
                end
            end
            HSPS_OCREG: begin
                if (tick_us) begin
                    s_d.itv = s_q.itv + 16'h0001;
                end
                if (!raw_s.oc && !sc_any) begin
                    s_d.state = HSPS_NORMAL;
                end else if (s_q.itv >= 16'(OCR_US)) begin
                    s_d.state = HSPS_WAIT;
                    s_d.tmr   = 10'h000;
                end
            end
            default: begin
                s_d.state = HSPS_WAIT;
            end
        endcase
        if (s_q.state != HSPS_WAIT) begin
            if (acc) begin
                s_d.retry = 4'h0;
            end
            if (!start_ok) begin
                s_d.state = HSPS_WAIT;
                s_d.tmr   = 10'h000;
            end
        end
        s_d.gate = (s_d.state != HSPS_WAIT);
        s_d.chg  = (s_d.state == HSPS_CHARGE);
        s_d.regl = (s_d.state == HSPS_OCREG) || (sc_any && s_d.state != HSPS_WAIT);
        s_d.pg   = (s_d.state == HSPS_NORMAL) || (s_d.state == HSPS_OCREG);
        s_d.pg_n = !s_d.pg;
        // one wait cycle per access keeps readdata a registered value
        if ((avs_read_i || avs_write_i) && s_q.wait_r) begin
            s_d.wait_r = 1'b0;
            case (avs_address_i)
                `HSPS_OFS_CTRL: s_d.rdata = {31'h0, s_q.soft_dis};
                `HSPS_OFS_STAT: s_d.rdata = {18'h0, s_q.pg, flt.oc, s_q.dis, flt.ot,
                                             flt.ov, flt.uv, s_q.retry, 1'b0, s_q.state};
                `HSPS_OFS_TMR:  s_d.rdata = {22'h0, tmr_ms};
                default:        s_d.rdata = 32'h0000_0000;
            endcase
        end else begin
            s_d.wait_r = 1'b1;
        end
        if (avs_write_i && !s_q.wait_r && avs_address_i == `HSPS_OFS_CTRL
            && avs_byteenable_i[0]) begin
            s_d.soft_dis = avs_writedata_i[`HSPS_CTRL_SOFTDIS];
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s_q        <= '0;
            s_q.state  <= HSPS_WAIT;
            s_q.pg_n   <= 1'b1;
            s_q.wait_r <= 1'b1;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign avs_readdata_o     = s_q.rdata;
    assign avs_waitrequest_o  = s_q.wait_r;
    assign gate_on_o          = s_q.gate;
    assign charge_limit_sel_o = s_q.chg;
    assign regulate_o         = s_q.regl;
    assign power_ok_high_o    = s_q.pg;
    assign power_ok_low_n_o   = s_q.pg_n;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence s_launch;
        (s_q.state == HSPS_WAIT) ##1 (s_q.state == HSPS_CHARGE);
    endsequence

    property p_pg_compl;
        power_ok_low_n_o == !power_ok_high_o;
    endproperty
    a_pg_compl: assert property (p_pg_compl) else $error("pg pair not complementary");

    property p_uv_off;
        ce_i && flt.uv |=> !gate_on_o && !power_ok_high_o;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("gate on under uv");

    property p_ov_off;
        ce_i && flt.ov |=> !gate_on_o && !power_ok_high_o;
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("gate on under ov");

    property p_dis_acc;
        ce_i && flt.dis && !s_q.dis |=> s_q.dis ##0 !gate_on_o;
    endproperty
    a_dis_acc: assert property (p_dis_acc) else $error("disable not accepted");

    property p_sc_fast;
        ce_i && raw_s.sc && gate_on_o |=> regulate_o || !gate_on_o;
    endproperty
    a_sc_fast: assert property (p_sc_fast) else $error("short not pulled down");

    property p_ot_pg;
        ce_i && flt.ot |=> !power_ok_high_o;
    endproperty
    a_ot_pg: assert property (p_ot_pg) else $error("pg kept in overtemp");

    property p_chg_sel;
        charge_limit_sel_o |-> gate_on_o && !power_ok_high_o;
    endproperty
    a_chg_sel: assert property (p_chg_sel) else $error("charge limit misused");

    property p_launch;
        s_launch |-> $past(s_q.retry, 1) <= 4'(`HSPS_RETRY_MAX) && $past(s_q.tmr, 1) >= $past(tmr_ms, 1);
    endproperty
    a_launch: assert property (p_launch) else $error("launch without full timer");

    property p_pg_seq;
        $rose(power_ok_high_o) |-> $past(s_q.state, 2) == HSPS_PGDLY;
    endproperty
    a_pg_seq: assert property (p_pg_seq) else $error("pg without sequence");

    property p_oc_stop;
        ce_i && s_q.state == HSPS_OCREG && s_q.itv >= 16'(OCR_US) && raw_s.oc
            |=> !gate_on_o && !power_ok_high_o;
    endproperty
    a_oc_stop: assert property (p_oc_stop) else $error("regulation not ended");
endmodule
`default_nettype wire

// ==== testbench/hsps_load_model.sv ====
// load power module stand-in driven by the power-good pair
`timescale 1ns/1ns
`default_nettype none
module hsps_load_model #(
    parameter int CHG_CYC = 6
) (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic gate_on_i,
    input  wire logic power_ok_high_i,
    input  wire logic power_ok_low_n_i,
    input  wire logic overload_i,
    output logic      gate_full_o,
    output logic      overcurrent_o,
    output logic      load_on_o
);
    // ****************************************
    // capacitor charge and load draw
    // ****************************************
    int chg_q;
    // full enhancement only after the capacitor had time to charge
    always_ff @(posedge clock_i) begin
        if (reset_i || !gate_on_i) begin
            chg_q <= 0;
            gate_full_o <= 1'b0;
        end else if (chg_q < CHG_CYC) begin
            chg_q <= chg_q + 1;
        end else begin
            gate_full_o <= 1'b1;
        end
    end
    // load runs only when both power-good lines agree
    assign load_on_o = power_ok_high_i && !power_ok_low_n_i;
    assign overcurrent_o = overload_i && gate_on_i;
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the hot swap sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench import hsps_pkg::*;;
    // ****************************************
    // signals and instances
    // ****************************************
    localparam int TSTART = 1600;
    logic        clock_i;
    logic        reset_i;
    logic        uv, ov, dis_lo, dis_hi, ot, sc, ovl, ext_p, rd, wr;
    logic [9:0]  ext_ms;
    logic        ce;
    logic [3:0]  be;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic        wait_o, gate, chg, regl, pg, pg_n, gfull, oc, load_on;
    int          err_count, total_checks, cyc;

    hsps_top #(.US_CYC(2), .MS_US(4), .UV_US(4), .OV_US(4), .DIS_US(4), .OCF_US(2),
        .OT_US(2), .OCR_US(8), .PGD_US(8)) dut (
        .clock_i(clock_i), .reset_i(reset_i), .ce_i(ce), .undervolt_sense_i(uv),
        .overvolt_sense_i(ov), .disable_above_i(dis_hi), .disable_below_i(dis_lo),
        .overtemp_i(ot), .overcurrent_i(oc), .short_circuit_i(sc), .gate_full_i(gfull),
        .timer_ext_present_i(ext_p), .timer_ext_ms_i(ext_ms), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .gate_on_o(gate), .charge_limit_sel_o(chg), .regulate_o(regl),
        .power_ok_high_o(pg), .power_ok_low_n_o(pg_n));

    hsps_load_model u_load (
        .clock_i(clock_i), .reset_i(reset_i), .gate_on_i(gate), .power_ok_high_i(pg),
        .power_ok_low_n_i(pg_n), .overload_i(ovl), .gate_full_o(gfull),
        .overcurrent_o(oc), .load_on_o(load_on));

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    always @(posedge clock_i) cyc <= cyc + 1;

    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task chk_in(input string nm, input int lo, input int hi, input int g);
        total_checks++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    function logic pick(input int s);
        case (s)
            0: pick = gate;
            1: pick = pg;
            default: pick = regl;
        endcase
    endfunction
    task wait_lvl(input int s, input logic l, input int maxc);
        int n;
        n = 0;
        while (pick(s) !== l && n < maxc) begin
            @(posedge clock_i);
            n++;
        end
        if (pick(s) !== l) begin
            err_count++;
            $display("[FAIL] level %0d expected %0b seen timeout", s, l);
        end
    endtask
    // request held until the edge that sees waitrequest low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clock_i);
        end while (wait_o !== 1'b0);
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clock_i);
    endtask
    task set_pin(input int w, input logic l);
        case (w)
            0: uv <= l;
            1: ov <= l;
            2: dis_lo <= l;
            3: dis_hi <= l;
            4: ot <= l;
            5: ovl <= l;
            6: begin
                sc <= l;
                ovl <= l;
            end
            default: bus(1'b1, 4'h0, {31'h0, l});
        endcase
        @(posedge clock_i);
    endtask
    task give_verdict;
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task power_up(input string nm, input int t0);
        int t;
        wait_lvl(0, 1'b1, 2000);
        chk_in(nm, TSTART - 10, TSTART + 170, cyc - t0);
        chk("charge sel", 32'h1, chg);
        t = cyc;
        wait_lvl(1, 1'b1, 200);
        chk_in("pg delay", 18, 34, cyc - t);
        chk("pg_n", 32'h0, pg_n);
        chk("load on", 32'h1, load_on);
        chk("normal sel", 32'h0, chg);
        bus(1'b0, 4'h4, 32'h0);
        chk("state", 32'h2002, v);
    endtask
    task fault_case(input string nm, input int w, input int g, input int hi, input int bit_i);
        int t;
        if (g > 0) begin
            set_pin(w, 1'b1);
            repeat (g - 1) @(posedge clock_i);
            set_pin(w, 1'b0);
            repeat (30) @(posedge clock_i);
            chk("glitch", 32'h1, pg);
        end
        set_pin(w, 1'b1);
        t = cyc;
        wait_lvl(1, 1'b0, 100);
        chk_in(nm, 3, hi, cyc - t);
        repeat (60) @(posedge clock_i);
        bus(1'b0, 4'h4, 32'h0);
        chk("flag", 32'h1, v[bit_i]);
        chk("held off", 32'h0, {pg, gate, !pg_n, load_on});
        set_pin(w, 1'b0);
        power_up(nm, cyc);
    endtask
    task oc_case(input string nm, input int w, input int hold);
        int t;
        set_pin(w, 1'b1);
        t = cyc;
        wait_lvl(2, 1'b1, 60);
        chk_in(nm, w == 6 ? 0 : 6, w == 6 ? 5 : 16, cyc - t);
        chk("pg kept", 32'h1, pg);
        if (hold < 16) begin
            repeat (hold) @(posedge clock_i);
            set_pin(w, 1'b0);
            repeat (30) @(posedge clock_i);
            chk("back normal", 32'h6, {pg, gate, regl});
        end else begin
            t = cyc;
            wait_lvl(0, 1'b0, 100);
            chk_in("oc off", 12, 30, cyc - t);
            chk("oc pg", 32'h1, {pg, pg_n});
            set_pin(w, 1'b0);
            power_up(nm, t);
        end
    endtask
    // a long fault pulse while frozen must leave no trace
    task freeze_case;
        ce <= 1'b0;
        set_pin(0, 1'b1);
        repeat (40) @(posedge clock_i);
        chk("frozen", 32'h6, {pg, gate, pg_n});
        set_pin(0, 1'b0);
        ce <= 1'b1;
        repeat (30) @(posedge clock_i);
        chk("thawed", 32'h6, {pg, gate, pg_n});
    endtask
    // overtemp pulses in wait exhaust retries, a disable clears them
    task retry_case;
        set_pin(4, 1'b1);
        repeat (20) @(posedge clock_i);
        for (int i = 0; i < 11; i++) begin
            set_pin(4, 1'b0);
            repeat (20) @(posedge clock_i);
            set_pin(4, 1'b1);
            repeat (20) @(posedge clock_i);
        end
        bus(1'b0, 4'h4, 32'h0);
        chk("retry count", 32'hB, v[7:4]);
        set_pin(4, 1'b0);
        repeat (1800) @(posedge clock_i);
        chk("retry stop", 32'h0, gate);
        set_pin(7, 1'b1);
        repeat (30) @(posedge clock_i);
        bus(1'b0, 4'h4, 32'h0);
        chk("retry clear", 32'h0, v[7:4]);
        set_pin(7, 1'b0);
        power_up("retry", cyc);
    endtask

    initial begin
        {uv, ov, dis_lo, dis_hi, ot, sc, ovl, ext_p, rd, wr} = 10'h0;
        {ext_ms, addr, wdata} = 46'h0;
        {err_count, total_checks, cyc} = 0;
        ce = 1'b1;
        be = 4'hF;
        reset_i = 1'b1;
        repeat (12) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        chk("reset outs", 32'h3, {gate, pg, pg_n, wait_o});
        bus(1'b0, 4'h4, 32'h0);
        chk("reset stat", 32'h0, v);
        bus(1'b0, 4'h8, 32'h0);
        chk("tmr default", 32'd200, v);
        ext_p <= 1'b1;
        ext_ms <= 10'd50;
        bus(1'b0, 4'h8, 32'h0);
        chk("tmr min", 32'd100, v);
        ext_ms <= 10'h3FF;
        bus(1'b0, 4'h8, 32'h0);
        chk("tmr max", 32'd1000, v);
        ext_p <= 1'b0;
        bus(1'b0, 4'hC, 32'h0);
        chk("unmapped", 32'h0, v);
        be <= 4'h0;
        bus(1'b1, 4'h0, 32'h1);
        be <= 4'hF;
        bus(1'b0, 4'h0, 32'h0);
        chk("be ignored", 32'h0, v);
        power_up("startup", 0);
        freeze_case();
        fault_case("uv", 0, 5, 24, 8);
        fault_case("ov", 1, 5, 24, 9);
        fault_case("dis lo", 2, 5, 24, 11);
        fault_case("dis hi", 3, 5, 24, 11);
        fault_case("ot", 4, 2, 16, 10);
        fault_case("soft", 7, 0, 24, 11);
        oc_case("oc short", 5, 6);
        oc_case("oc long", 5, 40);
        oc_case("sc", 6, 40);
        retry_case();
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge clock_i);
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
